// ### rtl/cdupc_defs.vh
// Offsets, field positions, codes and class defaults of the pin config bank
`ifndef CDUPC_DEFS_VH
`define CDUPC_DEFS_VH

// ---------------------------------------------------------------
// Bank offsets
// ---------------------------------------------------------------
`define CDUPC_OFS_HW_CONFIG   8'h00
`define CDUPC_OFS_OVERRIDES   8'h07
`define CDUPC_OFS_FLOW        8'h08
`define CDUPC_OFS_MODE_LO     8'h09
`define CDUPC_OFS_MODE_HI     8'h0a
`define CDUPC_OFS_DIR_LO      8'h0b
`define CDUPC_OFS_DIR_HI      8'h0c
`define CDUPC_OFS_MASK_LO     8'h0d
`define CDUPC_OFS_MASK_HI     8'h0e
`define CDUPC_BANK_WORDS      15
`define CDUPC_LOAD_LAST       4'he

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CDUPC_LOCK_BIT        6
`define CDUPC_OVR_FLOW        0
`define CDUPC_OVR_MODE        1
`define CDUPC_OVR_DIR         2
`define CDUPC_OVR_MASK        3
`define CDUPC_HALF_DUPLEX     3
`define CDUPC_FLOW_MODE       2:0
`define CDUPC_CLK_EN          7
`define CDUPC_XCVR_SEL        6:5
`define CDUPC_XCVR_PIN        4
`define CDUPC_PIN_FN          2:0
`define CDUPC_RX_TOGGLE       1
`define CDUPC_TX_TOGGLE       0
`define CDUPC_HIGH_PAIR       1:0

// ---------------------------------------------------------------
// Codes
// ---------------------------------------------------------------
`define CDUPC_FLOW_NONE       3'h0
`define CDUPC_FLOW_HW         3'h1
`define CDUPC_FLOW_SW         3'h2
`define CDUPC_FLOW_MD_RX      3'h3
`define CDUPC_FLOW_MD_ALL     3'h4
`define CDUPC_FN_GPIO         3'h0
`define CDUPC_FN_RTS_CTS      3'h1
`define CDUPC_FN_DTR_DSR      3'h2
`define CDUPC_FN_EN_TX        3'h3
`define CDUPC_FN_EN_MATCH     3'h4
`define CDUPC_SEL_GPIO        2'h0
`define CDUPC_SEL_EN_TX       2'h1
`define CDUPC_SEL_EN_MATCH    2'h2

// ---------------------------------------------------------------
// Class defaults used when an override is not selected
// ---------------------------------------------------------------
`define CDUPC_DEF_FLOW        8'h00
`define CDUPC_DEF_MODE_LO     8'h00
`define CDUPC_DEF_MODE_HI     8'h03
`define CDUPC_DEF_DIR         10'h000
`define CDUPC_DEF_MASK        10'h000

// ---------------------------------------------------------------
// Pin numbers
// ---------------------------------------------------------------
`define CDUPC_PIN_DTR         2
`define CDUPC_PIN_DSR         3
`define CDUPC_PIN_CTS         4
`define CDUPC_PIN_RTS         5
`define CDUPC_PIN_CLK         6
`define CDUPC_PIN_XCVR        7
`define CDUPC_PIN_TXT         8
`define CDUPC_PIN_RXT         9

`endif

// ### rtl/cdupc_gpio_sync.v
// Two-stage synchroniser and change detector for the GPIO input pins
`timescale 1ns/100ps

module cdupc_gpio_sync #(
	parameter W = 10
) (
	input  wire         clk,
	input  wire         srst,
	input  wire [W-1:0] pin_in,
	output reg  [W-1:0] level,
	output reg  [W-1:0] changed
);

	reg [W-1:0] meta;
	reg [W-1:0] prev;
	reg [1:0]   arm_cnt;
	wire        armed;

	assign armed = (arm_cnt == 2'h3);

	// ---------------------------------------------------------------
	// Arm counter
	// ---------------------------------------------------------------
	// Change reports wait until the pipe holds real pin values
	always @(posedge clk) begin
		if (srst)
			arm_cnt <= 2'h0;
		else if (!armed)
			arm_cnt <= arm_cnt + 2'h1;
	end

	// ---------------------------------------------------------------
	// Per-bit pipe
	// ---------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge clk) begin
				if (srst) begin
					meta[i]    <= 1'b0;
					level[i]   <= 1'b0;
					prev[i]    <= 1'b0;
					changed[i] <= 1'b0;
				end else begin
					meta[i]    <= pin_in[i];
					level[i]   <= meta[i];
					prev[i]    <= level[i];
					changed[i] <= armed & (level[i] ^ prev[i]);
				end
			end
		end
	endgenerate

endmodule // cdupc_gpio_sync

// ### rtl/cdupc_pin_config.v
// Default pin and flow configuration bank with power-up load and pin mux
//
// Functional notes
// - Half-duplex set drops receive data while transmitting; clear allows both.
// - Flow mode 000 none, 001 hardware flow, 010 software flow.
// - Mode 011 accepts receive only after address match; transmit free.
// - Mode 100 receives and transmits only after address match.
// - Low mode bit 7 puts clock output on GPIO6, else GPIO.
// - Select 00 GPIO7 plain, 01 enable on transmit, 10 on match.
// - Pin bit 0 keeps GPIO7 plain; 1 lets select field drive GPIO7.
// - Pin function 000 GPIO, 001 RTS/CTS on 5/4, 010 DTR/DSR 2/3.
// - Pin function 011/100 drives transceiver enable on GPIO5.
// - High mode bit 1, default 1, gives receive toggle on GPIO9.
// - High mode bit 0, default 1, gives transmit toggle on GPIO8.
// - One direction bit per GPIO, 1 output, 0 input, ten bits.
// - Unmasked input change requests an interrupt packet; mask 1 blocks.
// - Stored flow, mode, direction and mask values apply only when their override enable bit is set.
// - Bank contents copied to working registers only in the load after each reset.
// - Once lock loaded at reset, all bank writes are refused.
`timescale 1ns/100ps
`include "cdupc_defs.vh"

module cdupc_pin_config #(
	parameter NGPIO = 10
) (
	input  wire             clk,
	input  wire             srst,
	input  wire             otp_blank,
	input  wire [7:0]       reg_addr,
	input  wire             reg_wr,
	input  wire             reg_rd,
	input  wire [7:0]       reg_wdata,
	output reg  [7:0]       reg_rdata,
	output reg              reg_done,
	output reg              reg_refused,
	input  wire             uart_tx_active,
	input  wire             uart_addr_match,
	input  wire             uart_rx_room,
	input  wire             uart_rx_valid,
	input  wire [7:0]       uart_rx_data,
	input  wire             clk_src,
	input  wire             tx_toggle,
	input  wire             rx_toggle,
	input  wire [NGPIO-1:0] gpio_drive,
	input  wire [NGPIO-1:0] gpio_in,
	input  wire             irq_ack,
	output reg  [NGPIO-1:0] gpio_out,
	output reg  [NGPIO-1:0] gpio_oe,
	output reg  [NGPIO-1:0] gpio_level,
	output reg              rx_char_valid,
	output reg  [7:0]       rx_char_data,
	output reg              tx_permit,
	output reg              hw_flow_en,
	output reg              sw_flow_en,
	output reg              irq_pending,
	output reg  [NGPIO-1:0] irq_bits,
	output reg              cfg_ready,
	output reg              lock_active
);

	localparam ST_LOAD  = 2'h0;
	localparam ST_APPLY = 2'h1;
	localparam ST_RUN   = 2'h2;

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	// One-time bank; srst does not touch it, only otp_blank clears it
	reg  [7:0]       otp_mem [0:`CDUPC_BANK_WORDS-1];

	reg  [1:0]       state;
	reg  [3:0]       ld_idx;
	reg  [7:0]       raw_hw;
	reg  [7:0]       raw_ovr;
	reg  [7:0]       raw_flow;
	reg  [7:0]       raw_mode_lo;
	reg  [7:0]       raw_mode_hi;
	reg  [NGPIO-1:0] raw_dir;
	reg  [NGPIO-1:0] raw_mask;

	reg  [7:0]       cfg_flow;
	reg  [7:0]       cfg_mode_lo;
	reg  [7:0]       cfg_mode_hi;
	reg  [NGPIO-1:0] cfg_dir;
	reg  [NGPIO-1:0] cfg_mask;

	wire [NGPIO-1:0] pin_level;
	wire [NGPIO-1:0] pin_changed;
	wire             req;
	wire             addr_hit;
	wire [3:0]       addr_idx;
	integer          k;

	assign req      = reg_wr | reg_rd;
	assign addr_hit = (reg_addr < `CDUPC_BANK_WORDS);
	assign addr_idx = reg_addr[3:0];

	// ---------------------------------------------------------------
	// Bank writes and reads
	// ---------------------------------------------------------------
	// Writes only set bits, as a fuse array would
	always @(posedge clk) begin
		if (otp_blank) begin
			for (k = 0; k < `CDUPC_BANK_WORDS; k = k + 1)
				otp_mem[k] <= 8'h00;
		end else if (reg_wr && addr_hit && state == ST_RUN &&
		             !lock_active) begin
			otp_mem[addr_idx] <= otp_mem[addr_idx] | reg_wdata;
		end
	end

	// A write and a read in one cycle count as a write
	always @(posedge clk) begin
		if (srst) begin
			reg_rdata   <= 8'h00;
			reg_done    <= 1'b0;
			reg_refused <= 1'b0;
		end else begin
			reg_done    <= 1'b0;
			reg_refused <= 1'b0;
			if (req) begin
				if (state != ST_RUN || !addr_hit) begin
					reg_refused <= 1'b1;
					reg_rdata   <= 8'h00;
				end else if (reg_wr) begin
					reg_refused <= lock_active;
					reg_done    <= !lock_active;
					reg_rdata   <= 8'h00;
				end else begin
					reg_done    <= 1'b1;
					reg_rdata   <= otp_mem[addr_idx];
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Power-up load
	// ---------------------------------------------------------------
	// Working values change only here, so a newly written field has
	// no effect until the next reset
	always @(posedge clk) begin
		if (srst) begin
			state       <= ST_LOAD;
			ld_idx      <= 4'h0;
			raw_hw      <= 8'h00;
			raw_ovr     <= 8'h00;
			raw_flow    <= 8'h00;
			raw_mode_lo <= 8'h00;
			raw_mode_hi <= 8'h00;
			raw_dir     <= {NGPIO{1'b0}};
			raw_mask    <= {NGPIO{1'b0}};
			cfg_flow    <= `CDUPC_DEF_FLOW;
			cfg_mode_lo <= `CDUPC_DEF_MODE_LO;
			cfg_mode_hi <= `CDUPC_DEF_MODE_HI;
			cfg_dir     <= `CDUPC_DEF_DIR;
			cfg_mask    <= `CDUPC_DEF_MASK;
			cfg_ready   <= 1'b0;
			lock_active <= 1'b0;
		end else begin
			case (state)
				ST_LOAD: begin
					case ({4'h0, ld_idx})
						`CDUPC_OFS_HW_CONFIG: raw_hw      <= otp_mem[ld_idx];
						`CDUPC_OFS_OVERRIDES: raw_ovr     <= otp_mem[ld_idx];
						`CDUPC_OFS_FLOW:      raw_flow    <= otp_mem[ld_idx];
						`CDUPC_OFS_MODE_LO:   raw_mode_lo <= otp_mem[ld_idx];
						`CDUPC_OFS_MODE_HI:   raw_mode_hi <= otp_mem[ld_idx];
						`CDUPC_OFS_DIR_LO:    raw_dir[7:0]  <= otp_mem[ld_idx];
						`CDUPC_OFS_DIR_HI:
							raw_dir[9:8]  <= otp_mem[ld_idx][`CDUPC_HIGH_PAIR];
						`CDUPC_OFS_MASK_LO:   raw_mask[7:0] <= otp_mem[ld_idx];
						`CDUPC_OFS_MASK_HI:
							raw_mask[9:8] <= otp_mem[ld_idx][`CDUPC_HIGH_PAIR];
						default: ;
					endcase
					if (ld_idx == `CDUPC_LOAD_LAST)
						state <= ST_APPLY;
					else
						ld_idx <= ld_idx + 4'h1;
				end
				ST_APPLY: begin
					if (raw_ovr[`CDUPC_OVR_FLOW])
						cfg_flow <= raw_flow;
					if (raw_ovr[`CDUPC_OVR_MODE]) begin
						cfg_mode_lo <= raw_mode_lo;
						cfg_mode_hi <= raw_mode_hi;
					end
					if (raw_ovr[`CDUPC_OVR_DIR])
						cfg_dir <= raw_dir;
					if (raw_ovr[`CDUPC_OVR_MASK])
						cfg_mask <= raw_mask;
					lock_active <= raw_hw[`CDUPC_LOCK_BIT];
					cfg_ready   <= 1'b1;
					state       <= ST_RUN;
				end
				ST_RUN: ;
				default: state <= ST_LOAD;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Input pin synchroniser
	// ---------------------------------------------------------------
	cdupc_gpio_sync #(
		.W       (NGPIO)
	) u_sync (
		.clk     (clk),
		.srst    (srst),
		.pin_in  (gpio_in),
		.level   (pin_level),
		.changed (pin_changed)
	);

	// ---------------------------------------------------------------
	// Decoded configuration
	// ---------------------------------------------------------------
	wire [2:0] flow_mode;
	wire       half_duplex;
	wire [2:0] pin_fn;
	wire [1:0] xcvr_sel;
	wire       xcvr_pin7;
	wire       clk_out_en;
	wire       md_rx;
	wire       md_all;
	wire       hw_flow_mode;
	wire       tx_hold;
	wire       rx_accept;

	assign flow_mode   = cfg_flow[`CDUPC_FLOW_MODE];
	assign half_duplex = cfg_flow[`CDUPC_HALF_DUPLEX];
	assign pin_fn      = cfg_mode_lo[`CDUPC_PIN_FN];
	assign xcvr_sel    = cfg_mode_lo[`CDUPC_XCVR_SEL];
	assign xcvr_pin7   = cfg_mode_lo[`CDUPC_XCVR_PIN];
	assign clk_out_en  = cfg_mode_lo[`CDUPC_CLK_EN];
	assign md_rx       = (flow_mode == `CDUPC_FLOW_MD_RX);
	assign md_all      = (flow_mode == `CDUPC_FLOW_MD_ALL);
	assign hw_flow_mode = (flow_mode == `CDUPC_FLOW_HW);

	// Handshake inputs are active low; with no pin pair chosen there is
	// nothing to stop on, which the configuring party must avoid
	assign tx_hold = hw_flow_mode & (
		((pin_fn == `CDUPC_FN_RTS_CTS) & pin_level[`CDUPC_PIN_CTS]) |
		((pin_fn == `CDUPC_FN_DTR_DSR) & pin_level[`CDUPC_PIN_DSR]));

	assign rx_accept = !(half_duplex & uart_tx_active) &
	                   !((md_rx | md_all) & !uart_addr_match);

	// ---------------------------------------------------------------
	// Pin function mux
	// ---------------------------------------------------------------
	reg [NGPIO-1:0] next_gpio_out;
	reg [NGPIO-1:0] next_gpio_oe;
	reg [NGPIO-1:0] owned;

	always @* begin
		next_gpio_out = gpio_drive;
		next_gpio_oe  = cfg_dir;
		owned         = {NGPIO{1'b0}};
		case (pin_fn)
			`CDUPC_FN_GPIO: ;
			`CDUPC_FN_RTS_CTS: begin
				owned[`CDUPC_PIN_RTS]         = 1'b1;
				next_gpio_out[`CDUPC_PIN_RTS] = !uart_rx_room;
				next_gpio_oe[`CDUPC_PIN_RTS]  = 1'b1;
				owned[`CDUPC_PIN_CTS]         = 1'b1;
				next_gpio_oe[`CDUPC_PIN_CTS]  = 1'b0;
			end
			`CDUPC_FN_DTR_DSR: begin
				owned[`CDUPC_PIN_DTR]         = 1'b1;
				next_gpio_out[`CDUPC_PIN_DTR] = !uart_rx_room;
				next_gpio_oe[`CDUPC_PIN_DTR]  = 1'b1;
				owned[`CDUPC_PIN_DSR]         = 1'b1;
				next_gpio_oe[`CDUPC_PIN_DSR]  = 1'b0;
			end
			`CDUPC_FN_EN_TX: begin
				owned[`CDUPC_PIN_RTS]         = 1'b1;
				next_gpio_out[`CDUPC_PIN_RTS] = uart_tx_active;
				next_gpio_oe[`CDUPC_PIN_RTS]  = 1'b1;
			end
			`CDUPC_FN_EN_MATCH: begin
				owned[`CDUPC_PIN_RTS]         = 1'b1;
				next_gpio_out[`CDUPC_PIN_RTS] = uart_addr_match;
				next_gpio_oe[`CDUPC_PIN_RTS]  = 1'b1;
			end
			default: ;
		endcase
		if (clk_out_en) begin
			owned[`CDUPC_PIN_CLK]         = 1'b1;
			next_gpio_out[`CDUPC_PIN_CLK] = clk_src;
			next_gpio_oe[`CDUPC_PIN_CLK]  = 1'b1;
		end
		if (xcvr_pin7) begin
			case (xcvr_sel)
				`CDUPC_SEL_EN_TX: begin
					owned[`CDUPC_PIN_XCVR]         = 1'b1;
					next_gpio_out[`CDUPC_PIN_XCVR] = uart_tx_active;
					next_gpio_oe[`CDUPC_PIN_XCVR]  = 1'b1;
				end
				`CDUPC_SEL_EN_MATCH: begin
					owned[`CDUPC_PIN_XCVR]         = 1'b1;
					next_gpio_out[`CDUPC_PIN_XCVR] = uart_addr_match;
					next_gpio_oe[`CDUPC_PIN_XCVR]  = 1'b1;
				end
				default: ;
			endcase
		end
		if (cfg_mode_hi[`CDUPC_TX_TOGGLE]) begin
			owned[`CDUPC_PIN_TXT]         = 1'b1;
			next_gpio_out[`CDUPC_PIN_TXT] = tx_toggle;
			next_gpio_oe[`CDUPC_PIN_TXT]  = 1'b1;
		end
		if (cfg_mode_hi[`CDUPC_RX_TOGGLE]) begin
			owned[`CDUPC_PIN_RXT]         = 1'b1;
			next_gpio_out[`CDUPC_PIN_RXT] = rx_toggle;
			next_gpio_oe[`CDUPC_PIN_RXT]  = 1'b1;
		end
		// Pins stay undriven until the load has settled
		if (!cfg_ready)
			next_gpio_oe = {NGPIO{1'b0}};
	end

	// ---------------------------------------------------------------
	// Change events
	// ---------------------------------------------------------------
	wire [NGPIO-1:0] gpio_event;
	wire [NGPIO-1:0] next_irq_bits;

	// Only plain GPIO inputs report; masked ones never do
	assign gpio_event = pin_changed & ~cfg_dir & ~owned & ~cfg_mask &
	                    {NGPIO{cfg_ready}};
	// A change landing with the acknowledge survives it
	assign next_irq_bits = (irq_bits & ~{NGPIO{irq_ack}}) | gpio_event;

	// ---------------------------------------------------------------
	// Registered outputs
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			gpio_out      <= {NGPIO{1'b0}};
			gpio_oe       <= {NGPIO{1'b0}};
			gpio_level    <= {NGPIO{1'b0}};
			rx_char_valid <= 1'b0;
			rx_char_data  <= 8'h00;
			tx_permit     <= 1'b0;
			hw_flow_en    <= 1'b0;
			sw_flow_en    <= 1'b0;
			irq_bits      <= {NGPIO{1'b0}};
			irq_pending   <= 1'b0;
		end else begin
			gpio_out      <= next_gpio_out;
			gpio_oe       <= next_gpio_oe;
			gpio_level    <= pin_level;
			rx_char_valid <= cfg_ready & uart_rx_valid & rx_accept;
			rx_char_data  <= uart_rx_data;
			tx_permit     <= cfg_ready & !(md_all & !uart_addr_match) &
			                 !tx_hold;
			hw_flow_en    <= cfg_ready & hw_flow_mode;
			sw_flow_en    <= cfg_ready &
			                 (flow_mode == `CDUPC_FLOW_SW);
			irq_bits      <= next_irq_bits;
			irq_pending   <= |next_irq_bits;
		end
	end

endmodule // cdupc_pin_config

// ### tb/cdupc_pin_config_props.sv
// Port timing checker for the pin config bank
`timescale 1ns/100ps
module cdupc_pin_config_props #(
	parameter NGPIO = 10
) (
	input wire             clk,
	input wire             srst,
	input wire             reg_wr,
	input wire             reg_rd,
	input wire [7:0]       reg_addr,
	input wire             reg_done,
	input wire             reg_refused,
	input wire             cfg_ready,
	input wire             lock_active,
	input wire             uart_rx_valid,
	input wire             rx_char_valid,
	input wire [NGPIO-1:0] gpio_oe,
	input wire [NGPIO-1:0] irq_bits,
	input wire             irq_pending,
	input wire             irq_ack
);
	// ---------------------------------------------------------------
	// Answers, load and events
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	wire req = reg_wr | reg_rd;
	property p_answer; req |=> reg_done ^ reg_refused; endproperty
	a_answer: assert property (p_answer) else $error("bad answer");
	property p_idle; !req |=> !reg_done && !reg_refused; endproperty
	a_idle: assert property (p_idle) else $error("stray answer");
	property p_early; req && !cfg_ready |=> reg_refused; endproperty
	a_early: assert property (p_early) else $error("early taken");
	property p_unmap; req && reg_addr >= 8'h0f |=> reg_refused; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped taken");
	property p_lock; reg_wr && lock_active |=> reg_refused; endproperty
	a_lock: assert property (p_lock) else $error("locked write");
	property p_lock_load; $rose(lock_active) |-> $rose(cfg_ready); endproperty
	a_lock_load: assert property (p_lock_load) else $error("lock moved");
	property p_load; $fell(srst) |-> ##15 !cfg_ready ##1 cfg_ready; endproperty
	a_load: assert property (p_load) else $error("load time");
	property p_oe_idle; !cfg_ready |-> gpio_oe == '0; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("early drive");
	property p_rx; rx_char_valid |-> $past(uart_rx_valid); endproperty
	a_rx: assert property (p_rx) else $error("rx without cause");
	// Sticky bits may only drop on an acknowledge
	property p_sticky;
		!irq_ack |=> (irq_bits & $past(irq_bits)) == $past(irq_bits);
	endproperty
	a_sticky: assert property (p_sticky) else $error("event lost");
	property p_pend; irq_pending == (|irq_bits); endproperty
	a_pend: assert property (p_pend) else $error("pending wrong");
endmodule // cdupc_pin_config_props

bind cdupc_pin_config cdupc_pin_config_props #(.NGPIO(NGPIO)) u_props (
	.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_done(reg_done), .reg_refused(reg_refused),
	.cfg_ready(cfg_ready), .lock_active(lock_active),
	.uart_rx_valid(uart_rx_valid), .rx_char_valid(rx_char_valid),
	.gpio_oe(gpio_oe), .irq_bits(irq_bits), .irq_pending(irq_pending),
	.irq_ack(irq_ack)
);

// ### tb/cdupc_pin_config_tb_top.sv
// Self-checking bench of the pin config bank
`timescale 1ns/100ps
module cdupc_pin_config_tb_top;
	reg        clk = 1'b0, srst = 1'b1, otp_blank = 1'b0;
	reg  [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, uart_rx_data = 8'h00;
	reg        reg_wr = 1'b0, reg_rd = 1'b0, irq_ack = 1'b0;
	reg        uart_tx_active = 1'b0, uart_addr_match = 1'b0;
	reg        uart_rx_room = 1'b0, uart_rx_valid = 1'b0, clk_src = 1'b0;
	reg        tx_toggle = 1'b0, rx_toggle = 1'b0;
	reg  [9:0] gpio_drive = 10'h000, gpio_in = 10'h000;
	wire [7:0] reg_rdata, rx_char_data;
	wire       reg_done, reg_refused, rx_char_valid, tx_permit;
	wire       hw_flow_en, sw_flow_en, irq_pending, cfg_ready, lock_active;
	wire [9:0] gpio_out, gpio_oe, gpio_level, irq_bits;
	reg  [7:0] rd;
	reg        dn, rf;
	integer    n_mismatch = 0, num_checks = 0;

	cdupc_pin_config #(.NGPIO(10)) uut (
		.clk(clk), .srst(srst), .otp_blank(otp_blank), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_done(reg_done), .reg_refused(reg_refused),
		.uart_tx_active(uart_tx_active), .uart_addr_match(uart_addr_match),
		.uart_rx_room(uart_rx_room), .uart_rx_valid(uart_rx_valid),
		.uart_rx_data(uart_rx_data), .clk_src(clk_src),
		.tx_toggle(tx_toggle), .rx_toggle(rx_toggle),
		.gpio_drive(gpio_drive), .gpio_in(gpio_in), .irq_ack(irq_ack),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_level(gpio_level),
		.rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
		.tx_permit(tx_permit), .hw_flow_en(hw_flow_en),
		.sw_flow_en(sw_flow_en), .irq_pending(irq_pending),
		.irq_bits(irq_bits), .cfg_ready(cfg_ready), .lock_active(lock_active)
	);

	always #2.5 clk = ~clk;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", num_checks, n_mismatch);
			if (n_mismatch == 0 && num_checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask

	task chk(input [15:0] seen, input [15:0] exp);
		begin
			num_checks = num_checks + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask

	task cyc(input integer n);
		begin
			repeat (n) @(negedge clk);
		end
	endtask

	// Request is a one-cycle pulse; the answer stands only in the cycle
	// after the taking edge, so it is captured before the request drops
	task xfer(input w, input [7:0] a, input [7:0] d);
		begin
			reg_wr = w;
			reg_rd = !w;
			reg_addr = a;
			reg_wdata = d;
			cyc(1);
			rd = reg_rdata;
			dn = reg_done;
			rf = reg_refused;
			reg_wr = 1'b0;
			reg_rd = 1'b0;
			cyc(1);
		end
	endtask

	task wr_ok(input [7:0] a, input [7:0] d);
		begin
			xfer(1'b1, a, d);
			chk({dn, rf}, 2'b10);
		end
	endtask

	task do_reset;
		begin
			srst = 1'b1;
			cyc(8);
			srst = 1'b0;
			cyc(17);
		end
	endtask

	// Bytes of v go to offsets 0x07 up to 0x0e, lowest byte first
	task setup(input [63:0] v);
		integer i;
		begin
			otp_blank = 1'b1;
			cyc(1);
			otp_blank = 1'b0;
			do_reset;
			for (i = 0; i < 8; i = i + 1)
				wr_ok(8'h07 + i[7:0], v[8*i +: 8]);
		end
	endtask

	task rx(input t, input m, input ev, input ep);
		begin
			uart_tx_active = t;
			uart_addr_match = m;
			uart_rx_valid = 1'b1;
			uart_rx_data = 8'h5a;
			cyc(1);
			uart_rx_valid = 1'b0;
			chk(rx_char_valid, ev);
			chk(tx_permit, ep);
			if (ev)
				chk(rx_char_data, 8'h5a);
		end
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task t_defaults;
		integer i;
		begin
			srst = 1'b0;
			cyc(2);
			xfer(1'b0, 8'h08, 8'h00);
			chk(rf, 1'b1);
			cyc(20);
			chk({cfg_ready, gpio_oe}, 11'h700);
			tx_toggle = 1'b1;
			cyc(1);
			chk(gpio_out[9:8], 2'b01);
			for (i = 0; i < 16; i = i + 1) begin
				xfer(1'b0, i[7:0], 8'h00);
				chk({rd, dn, rf}, (i < 15) ? 10'h002 : 10'h001);
			end
		end
	endtask

	task t_multidrop_rx;
		begin
			setup(64'h00_02_00_01_02_b4_0b_0f);
			xfer(1'b0, 8'h09, 8'h00);
			chk(rd, 8'hb4);
			chk(gpio_oe, 10'h300);
			do_reset;
			chk(gpio_oe, 10'h2e1);
			clk_src = 1'b1;
			rx_toggle = 1'b1;
			gpio_drive = 10'h001;
			rx(1'b1, 1'b0, 1'b0, 1'b1);
			chk({gpio_out[9], gpio_out[7:5], gpio_out[0]}, 5'b11101);
			rx(1'b1, 1'b1, 1'b0, 1'b1);
			rx(1'b0, 1'b0, 1'b0, 1'b1);
			rx(1'b0, 1'b1, 1'b1, 1'b1);
			gpio_in = 10'h006;
			cyc(6);
			chk({irq_pending, irq_bits}, 11'h404);
			chk(gpio_level[2:1], 2'b11);
			irq_ack = 1'b1;
			cyc(1);
			irq_ack = 1'b0;
			cyc(1);
			chk({irq_pending, irq_bits}, 11'h000);
			gpio_in = 10'h000;
		end
	endtask

	task t_hw_flow;
		begin
			setup(64'h00_00_00_00_00_01_01_03);
			wr_ok(8'h00, 8'h40);
			do_reset;
			chk({lock_active, hw_flow_en, sw_flow_en}, 3'b110);
			chk(gpio_oe, 10'h020);
			uart_rx_room = 1'b1;
			gpio_in = 10'h010;
			cyc(6);
			chk({gpio_out[5], tx_permit, irq_bits[4]}, 3'b000);
			gpio_in = 10'h000;
			cyc(6);
			chk(tx_permit, 1'b1);
			xfer(1'b1, 8'h0d, 8'hff);
			chk(rf, 1'b1);
			xfer(1'b0, 8'h08, 8'h00);
			chk({rd, dn}, 9'h003);
			xfer(1'b0, 8'h0d, 8'h00);
			chk({rd, dn, rf}, 10'h002);
		end
	endtask

	task t_sw_flow;
		begin
			setup(64'h00_00_00_00_01_52_02_03);
			do_reset;
			chk({lock_active, hw_flow_en, sw_flow_en}, 3'b001);
			chk(gpio_oe, 10'h184);
			uart_rx_room = 1'b0;
			uart_addr_match = 1'b1;
			cyc(1);
			chk({gpio_out[8:7], gpio_out[2]}, 3'b111);
		end
	endtask

	task t_multidrop_all;
		begin
			setup(64'h00_00_00_00_00_03_04_03);
			do_reset;
			chk(gpio_oe[7:5], 3'b001);
			rx(1'b1, 1'b0, 1'b0, 1'b0);
			chk(gpio_out[5], 1'b1);
			rx(1'b0, 1'b1, 1'b1, 1'b1);
		end
	endtask

	task t_no_override;
		begin
			setup(64'h00_00_00_ff_00_01_01_00);
			do_reset;
			chk({hw_flow_en, sw_flow_en}, 2'b00);
			chk(gpio_oe, 10'h300);
			rx(1'b1, 1'b0, 1'b1, 1'b1);
		end
	endtask

	initial begin
		otp_blank = 1'b1;
		cyc(1);
		otp_blank = 1'b0;
		cyc(7);
		t_defaults;
		t_multidrop_rx;
		t_hw_flow;
		t_sw_flow;
		t_multidrop_all;
		t_no_override;
		give_verdict;
	end

	// Whole run is well under 1000 cycles
	initial begin
		#20000;
		n_mismatch = n_mismatch + 1;
		give_verdict;
	end
endmodule // cdupc_pin_config_tb_top
